/* File: verilog/card_timing_pkg.sv */
package card_timing_pkg;

    // ------------------------------------------------------------
    // register offsets on the bus
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_TIMING = 8'h00;
    localparam logic [7:0] OFS_WAIT   = 8'h04;
    localparam logic [7:0] OFS_ADDR   = 8'h08;
    localparam logic [7:0] OFS_WDATA  = 8'h0c;
    localparam logic [7:0] OFS_CMD    = 8'h10;
    localparam logic [7:0] OFS_RDATA  = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ------------------------------------------------------------
    // card_strobe_timing_ctrl layout
    // ------------------------------------------------------------
    localparam logic [15:0] TCR_RESET   = 16'h0000;
    localparam logic [15:0] TCR_WMASK   = 16'hcfff;
    localparam int          A6_UP_POS   = 15;
    localparam int          A5_UP_POS   = 14;
    localparam int          A5_DLY2_POS = 11;
    localparam int          A6_DLY2_POS = 10;
    localparam int          A5_HLD2_POS = 9;
    localparam int          A6_HLD2_POS = 8;
    localparam int          A5TED_LO    = 6;
    localparam int          A6TED_LO    = 4;
    localparam int          A5TEH_LO    = 2;
    localparam int          A6TEH_LO    = 0;

    // ------------------------------------------------------------
    // area_wait_control_reg layout
    // ------------------------------------------------------------
    localparam logic [15:0] WCR_RESET   = 16'h0077;
    localparam logic [15:0] WCR_WMASK   = 16'h0377;
    localparam int          A5W_LO      = 0;
    localparam int          A6W_LO      = 4;
    localparam int          A5_CARD_POS = 8;
    localparam int          A6_CARD_POS = 9;

    // ------------------------------------------------------------
    // command and status fields
    // ------------------------------------------------------------
    localparam int CMD_AREA_POS  = 0;
    localparam int CMD_WRITE_POS = 1;
    localparam int CMD_BEATS_LO  = 4;
    localparam int ST_BUSY_POS   = 0;
    localparam int ST_DONE_POS   = 1;
    localparam int ST_REFUSE_POS = 2;

    typedef enum logic [1:0] {IDLE, SETUP, STROBE, HOLD} seq_state_e;

    // first-cycle wait states per four-bit wait code
    function automatic logic [5:0] first_waits(input logic [3:0] code);
        logic [5:0] w;
        w = 6'h00;
        case (code)
            4'h0: w = 6'h00;
            4'h1: w = 6'h01;
            4'h2: w = 6'h02;
            4'h3: w = 6'h03;
            4'h4: w = 6'h04;
            4'h5: w = 6'h06;
            4'h6: w = 6'h08;
            4'h7: w = 6'h0a;
            4'h8: w = 6'h0c;
            4'h9: w = 6'h0e;
            4'ha: w = 6'h12;
            4'hb: w = 6'h16;
            4'hc: w = 6'h1a;
            4'hd: w = 6'h1e;
            4'he: w = 6'h22;
            4'hf: w = 6'h26;
        endcase
        return w;
    endfunction : first_waits

endpackage : card_timing_pkg

/* File: verilog/area_timing_if.sv */
`timescale 1ns/1ps
interface area_timing_if;
    logic [2:0] assert_dly;
    logic [2:0] hold_dly;
    logic [5:0] first_wait_n;
    logic [5:0] burst_states;
    logic       wait_en;
    logic       card_en;

    modport decoder (output assert_dly, hold_dly, first_wait_n,
                     burst_states, wait_en, card_en);
    modport sequencer (input assert_dly, hold_dly, first_wait_n,
                       burst_states, wait_en, card_en);
endinterface : area_timing_if

/* File: verilog/area_timing_decode.sv */
`timescale 1ns/1ps
module area_timing_decode #(
    parameter bit AREA6 = 1'b0
) (
    input  wire logic [15:0]   timing_ctrl,
    input  wire logic [15:0]   wait_ctrl,
    area_timing_if.decoder     tim
);
    logic [3:0] code;

    always_comb
    begin
        if (AREA6)
        begin
            code = {timing_ctrl[card_timing_pkg::A6_UP_POS],
                    wait_ctrl[card_timing_pkg::A6W_LO +: 3]};
            tim.assert_dly = {timing_ctrl[card_timing_pkg::A6_DLY2_POS],
                timing_ctrl[card_timing_pkg::A6TED_LO +: 2]};
            tim.hold_dly = {timing_ctrl[card_timing_pkg::A6_HLD2_POS],
                timing_ctrl[card_timing_pkg::A6TEH_LO +: 2]};
            tim.card_en = wait_ctrl[card_timing_pkg::A6_CARD_POS];
        end
        else
        begin
            code = {timing_ctrl[card_timing_pkg::A5_UP_POS],
                    wait_ctrl[card_timing_pkg::A5W_LO +: 3]};
            tim.assert_dly = {timing_ctrl[card_timing_pkg::A5_DLY2_POS],
                timing_ctrl[card_timing_pkg::A5TED_LO +: 2]};
            tim.hold_dly = {timing_ctrl[card_timing_pkg::A5_HLD2_POS],
                timing_ctrl[card_timing_pkg::A5TEH_LO +: 2]};
            tim.card_en = wait_ctrl[card_timing_pkg::A5_CARD_POS];
        end
        // strobe width comes from the wait code only
        tim.first_wait_n = card_timing_pkg::first_waits(code);
        tim.wait_en = (code != 4'h0);
        // burst beat: two states for codes 0 and 1, else waits plus one
        tim.burst_states = (code < 4'h2) ? 6'h02
                         : tim.first_wait_n + 6'h01;
    end
endmodule : area_timing_decode

/* File: verilog/card_strobe_ctrl.sv */
`timescale 1ns/1ps
module card_strobe_ctrl #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 16
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              manual_rst,
    input  wire logic              standby,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic      [ADDR_W-1:0] card_addr,
    output logic                   card_addr_oe,
    output logic                   card_ce5_n,
    output logic                   card_ce6_n,
    output logic                   card_oe_n,
    output logic                   card_we_n,
    input  wire logic              card_wait_n,
    input  wire logic [DATA_W-1:0] card_data_i,
    output logic      [DATA_W-1:0] card_data_o,
    output logic                   card_data_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0]                 timing;
        logic [15:0]                 wait_ctrl;
        logic [ADDR_W-1:0]           acc_addr;
        logic [DATA_W-1:0]           acc_wdata;
        logic [DATA_W-1:0]           rdata;
        logic                        cmd_area;
        logic                        cmd_write;
        logic [3:0]                  beats_left;
        logic                        first;
        logic                        busy;
        logic                        done;
        logic                        refused;
        card_timing_pkg::seq_state_e state;
        logic [5:0]                  cnt;
        logic [ADDR_W-1:0]           addr_out;
        logic [DATA_W-1:0]           data_out;
        logic                        addr_oe;
        logic                        data_oe;
        logic                        ce5_n;
        logic                        ce6_n;
        logic                        strobe_req;
        logic                        ap_valid;
        logic                        ap_write;
        logic [7:0]                  ap_addr;
        logic [31:0]                 hrdata;
        logic                        hreadyout;
        logic                        wait_s1;
        logic                        wait_s2;
        logic [DATA_W-1:0]           data_s1;
        logic [DATA_W-1:0]           data_s2;
        logic                        mrst_s1;
        logic                        mrst_s2;
        logic                        stby_s1;
        logic                        stby_s2;
    } state_s;

    state_s cur_ff;
    state_s nxt_cur;
    logic   oe_n_ff;
    logic   we_n_ff;

    area_timing_if a5_if ();
    area_timing_if a6_if ();

    area_timing_decode #(.AREA6(1'b0)) u_area5 (
        .timing_ctrl (cur_ff.timing),
        .wait_ctrl   (cur_ff.wait_ctrl),
        .tim         (a5_if)
    );

    area_timing_decode #(.AREA6(1'b1)) u_area6 (
        .timing_ctrl (cur_ff.timing),
        .wait_ctrl   (cur_ff.wait_ctrl),
        .tim         (a6_if)
    );

    // ------------------------------------------------------------
    // register read view
    // ------------------------------------------------------------
    function automatic logic [31:0] read_mux(input logic [7:0] a,
                                             input state_s s);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            card_timing_pkg::OFS_TIMING:
                r = {16'h0000, s.timing & card_timing_pkg::TCR_WMASK};
            card_timing_pkg::OFS_WAIT:   r = {16'h0000, s.wait_ctrl};
            card_timing_pkg::OFS_ADDR:   r = 32'(s.acc_addr);
            card_timing_pkg::OFS_WDATA:  r = 32'(s.acc_wdata);
            card_timing_pkg::OFS_RDATA:  r = 32'(s.rdata);
            card_timing_pkg::OFS_STATUS:
            begin
                r[card_timing_pkg::ST_BUSY_POS]   = s.busy;
                r[card_timing_pkg::ST_DONE_POS]   = s.done;
                r[card_timing_pkg::ST_REFUSE_POS] = s.refused;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction : read_mux

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    logic       start_req;
    logic       clr_done;
    logic       clr_refused;
    logic       new_area;
    logic [2:0] new_dly;
    logic [5:0] new_waits;
    logic       new_en;
    logic [5:0] sel_waits;
    logic [5:0] sel_burst;
    logic [2:0] sel_hold;
    logic       sel_wait_en;

    always_comb
    begin
        nxt_cur = cur_ff;
        start_req = 1'b0;
        clr_done = 1'b0;
        clr_refused = 1'b0;

        // pins from outside pass two flops before use
        nxt_cur.wait_s1 = ~card_wait_n;
        nxt_cur.wait_s2 = cur_ff.wait_s1;
        nxt_cur.data_s1 = card_data_i;
        nxt_cur.data_s2 = cur_ff.data_s1;
        nxt_cur.mrst_s1 = manual_rst;
        nxt_cur.mrst_s2 = cur_ff.mrst_s1;
        nxt_cur.stby_s1 = standby;
        nxt_cur.stby_s2 = cur_ff.stby_s1;

        // bus address phase; zero-wait slave, always OKAY
        nxt_cur.hreadyout = 1'b1;
        nxt_cur.ap_valid = hsel & hready & htrans[1];
        nxt_cur.ap_write = hwrite;
        nxt_cur.ap_addr = haddr[7:0];
        nxt_cur.hrdata = 32'h0000_0000;
        if (hsel && hready && htrans[1] && !hwrite)
            nxt_cur.hrdata = read_mux(haddr[7:0], cur_ff);

        // bus data phase
        if (cur_ff.ap_valid && cur_ff.ap_write)
        begin
            case (cur_ff.ap_addr)
                card_timing_pkg::OFS_TIMING:
                    nxt_cur.timing =
                        hwdata[15:0] & card_timing_pkg::TCR_WMASK;
                card_timing_pkg::OFS_WAIT:
                    nxt_cur.wait_ctrl =
                        hwdata[15:0] & card_timing_pkg::WCR_WMASK;
                card_timing_pkg::OFS_ADDR:
                    nxt_cur.acc_addr = hwdata[ADDR_W-1:0];
                card_timing_pkg::OFS_WDATA:
                    nxt_cur.acc_wdata = hwdata[DATA_W-1:0];
                card_timing_pkg::OFS_CMD:
                    start_req = 1'b1;
                card_timing_pkg::OFS_STATUS:
                begin
                    clr_done = hwdata[card_timing_pkg::ST_DONE_POS];
                    clr_refused = hwdata[card_timing_pkg::ST_REFUSE_POS];
                end
                default: ;
            endcase
        end
        if (clr_done)
            nxt_cur.done = 1'b0;
        if (clr_refused)
            nxt_cur.refused = 1'b0;

        // timing of the area in flight
        sel_waits   = cur_ff.cmd_area ? a6_if.first_wait_n
                                      : a5_if.first_wait_n;
        sel_burst   = cur_ff.cmd_area ? a6_if.burst_states
                                      : a5_if.burst_states;
        sel_hold    = cur_ff.cmd_area ? a6_if.hold_dly : a5_if.hold_dly;
        sel_wait_en = cur_ff.cmd_area ? a6_if.wait_en : a5_if.wait_en;

        // timing of the area a new command names
        new_area  = hwdata[card_timing_pkg::CMD_AREA_POS];
        new_dly   = new_area ? a6_if.assert_dly : a5_if.assert_dly;
        new_waits = new_area ? a6_if.first_wait_n : a5_if.first_wait_n;
        new_en    = new_area ? a6_if.card_en : a5_if.card_en;

        unique case (cur_ff.state)
            card_timing_pkg::IDLE: ;
            card_timing_pkg::SETUP:
            begin
                // address has been out for code cycles; strobe launches
                // half a cycle later on the falling edge
                if (cur_ff.cnt == 6'h00)
                begin
                    nxt_cur.state = card_timing_pkg::STROBE;
                    nxt_cur.strobe_req = 1'b1;
                    nxt_cur.cnt = sel_waits;
                end
                else
                    nxt_cur.cnt = cur_ff.cnt - 6'h01;
            end
            card_timing_pkg::STROBE:
            begin
                if (cur_ff.cnt != 6'h00)
                    nxt_cur.cnt = cur_ff.cnt - 6'h01;
                else if (cur_ff.wait_s2 &&
                         (sel_wait_en || !cur_ff.first))
                    nxt_cur.cnt = 6'h00;
                else
                begin
                    if (!cur_ff.cmd_write)
                        nxt_cur.rdata = cur_ff.data_s2;
                    if (cur_ff.beats_left != 4'h0)
                    begin
                        nxt_cur.beats_left = cur_ff.beats_left - 4'h1;
                        nxt_cur.addr_out = cur_ff.addr_out + ADDR_W'(1);
                        nxt_cur.first = 1'b0;
                        nxt_cur.cnt = sel_burst - 6'h01;
                    end
                    else
                    begin
                        nxt_cur.state = card_timing_pkg::HOLD;
                        nxt_cur.strobe_req = 1'b0;
                        nxt_cur.cnt = {3'h0, sel_hold};
                    end
                end
            end
            card_timing_pkg::HOLD:
            begin
                // address released code + 1 edges after the strobe
                // request fell, i.e. code + 0.5 after the pin negated
                if (cur_ff.cnt == 6'h00)
                begin
                    nxt_cur.state = card_timing_pkg::IDLE;
                    nxt_cur.addr_oe = 1'b0;
                    nxt_cur.data_oe = 1'b0;
                    nxt_cur.busy = 1'b0;
                    nxt_cur.done = 1'b1;
                end
                else
                    nxt_cur.cnt = cur_ff.cnt - 6'h01;
            end
        endcase

        // a card access; refused when busy, in standby, in manual reset
        // or when the area is not set up as a card area
        if (start_req)
        begin
            if (cur_ff.busy || cur_ff.stby_s2 || cur_ff.mrst_s2 || !new_en)
                nxt_cur.refused = 1'b1;
            else
            begin
                nxt_cur.cmd_area = new_area;
                nxt_cur.cmd_write = hwdata[card_timing_pkg::CMD_WRITE_POS];
                nxt_cur.beats_left = hwdata[card_timing_pkg::CMD_BEATS_LO +: 4];
                nxt_cur.first = 1'b1;
                nxt_cur.busy = 1'b1;
                nxt_cur.addr_out = cur_ff.acc_addr;
                nxt_cur.data_out = cur_ff.acc_wdata;
                nxt_cur.addr_oe = 1'b1;
                nxt_cur.data_oe = hwdata[card_timing_pkg::CMD_WRITE_POS];
                if (new_dly == 3'h0)
                begin
                    nxt_cur.state = card_timing_pkg::STROBE;
                    nxt_cur.strobe_req = 1'b1;
                    nxt_cur.cnt = new_waits;
                end
                else
                begin
                    nxt_cur.state = card_timing_pkg::SETUP;
                    nxt_cur.cnt = {3'h0, new_dly} - 6'h01;
                end
            end
        end

        // manual reset stops the access and clears busy but keeps every other register
        if (cur_ff.mrst_s2)
        begin
            nxt_cur.state = card_timing_pkg::IDLE;
            nxt_cur.strobe_req = 1'b0;
            nxt_cur.addr_oe = 1'b0;
            nxt_cur.data_oe = 1'b0;
            nxt_cur.busy = 1'b0;
        end

        nxt_cur.ce5_n = ~(nxt_cur.addr_oe & ~nxt_cur.cmd_area);
        nxt_cur.ce6_n = ~(nxt_cur.addr_oe & nxt_cur.cmd_area);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cur_ff <= '0;
            cur_ff.timing <= card_timing_pkg::TCR_RESET;
            cur_ff.wait_ctrl <= card_timing_pkg::WCR_RESET;
            cur_ff.state <= card_timing_pkg::IDLE;
            cur_ff.hreadyout <= 1'b1;
            cur_ff.ce5_n <= 1'b1;
            cur_ff.ce6_n <= 1'b1;
        end
        else
            cur_ff <= nxt_cur;
    end

    // strobes launch on the falling edge to give the half cycle
    always_ff @(negedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            oe_n_ff <= 1'b1;
            we_n_ff <= 1'b1;
        end
        else
        begin
            oe_n_ff <= ~(cur_ff.strobe_req & ~cur_ff.cmd_write);
            we_n_ff <= ~(cur_ff.strobe_req & cur_ff.cmd_write);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata       = cur_ff.hrdata;
    assign hreadyout    = cur_ff.hreadyout;
    assign hresp        = 1'b0;
    assign card_addr    = cur_ff.addr_out;
    assign card_addr_oe = cur_ff.addr_oe;
    assign card_ce5_n   = cur_ff.ce5_n;
    assign card_ce6_n   = cur_ff.ce6_n;
    assign card_oe_n    = oe_n_ff;
    assign card_we_n    = we_n_ff;
    assign card_data_o  = cur_ff.data_out;
    assign card_data_oe = cur_ff.data_oe;
endmodule : card_strobe_ctrl

/* File: tb/card_strobe_ctrl_assertions.sv */
`timescale 1ns/1ps
module card_strobe_ctrl_checker (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        card_addr_oe,
    input wire logic        card_ce5_n,
    input wire logic        card_ce6_n,
    input wire logic        card_oe_n,
    input wire logic        card_we_n,
    input wire logic        card_wait_n
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // --------------------------------
    // bus and strobe relations
    // --------------------------------
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not ready or not okay");
    AST_RDATA_UPPER: assert property (hrdata[31:16] == 16'h0)
        else $error("upper read data not zero");
    AST_IDLE_AFTER_RESET: assert property ($fell(rst) |-> card_ce5_n &&
        card_ce6_n && card_oe_n && card_we_n && !card_addr_oe)
        else $error("card side not idle after reset");
    AST_ONE_AREA: assert property (card_ce5_n || card_ce6_n)
        else $error("both areas selected");
    AST_ONE_STROBE: assert property (card_oe_n || card_we_n)
        else $error("both strobes low");
    AST_STROBE_INSIDE: assert property (!(card_oe_n && card_we_n) |->
        card_addr_oe && !(card_ce5_n && card_ce6_n))
        else $error("strobe outside address phase");
    AST_SETUP_HALF: assert property (@(negedge clk_sys)
        $rose(card_addr_oe) |-> card_oe_n && card_we_n)
        else $error("strobe with address");
    AST_ASSERT_LIMIT: assert property ($rose(card_addr_oe) |->
        ##[0:7] !(card_oe_n && card_we_n))
        else $error("strobe later than longest delay");
    AST_HOLD_HALF: assert property ($rose(card_oe_n && card_we_n) |->
        card_addr_oe)
        else $error("address dropped with strobe");
    cover property ($rose(card_addr_oe) && !card_ce5_n);
    cover property ($fell(card_we_n));
    cover property (!card_wait_n && !card_oe_n);
endmodule : card_strobe_ctrl_checker

bind card_strobe_ctrl card_strobe_ctrl_checker i_chk (.clk_sys, .rst,
    .hrdata, .hreadyout, .hresp, .card_addr_oe, .card_ce5_n, .card_ce6_n,
    .card_oe_n, .card_we_n, .card_wait_n);

/* File: tb/card_device_model.sv */
`timescale 1ns/1ps
module card_device_model (
    input wire logic        clk_sys,
    input wire logic [15:0] card_addr,
    input wire logic        card_ce5_n,
    input wire logic        card_ce6_n,
    input wire logic        card_oe_n,
    input wire logic        card_we_n,
    input wire logic [7:0]  wait_len,
    output logic            card_wait_n = 1'b1,
    output logic     [15:0] card_data_i = 16'h0
);
    int wc = 0;
    // released bus flips every cycle so stale data never passes
    always @(posedge clk_sys)
    begin
        if (!(card_ce5_n && card_ce6_n))
            card_data_i <= card_addr ^ 16'h5a5a;
        else
            card_data_i <= ~card_data_i;
        wc <= (card_oe_n && card_we_n) ? 0 : wc + 1;
        card_wait_n <= (card_oe_n && card_we_n) || wc >= wait_len;
    end
endmodule : card_device_model

/* File: tb/card_strobe_ctrl_bench.sv */
`timescale 1ns/1ps
module card_strobe_ctrl_bench;
    logic clk_sys = 0, rst = 1, manual_rst = 0, standby = 0;
    logic hsel = 0, hwrite = 0, hready, hreadyout, hresp;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    logic [1:0]  htrans = 0;
    logic [15:0] card_addr, card_data_i, card_data_o;
    logic card_addr_oe, card_ce5_n, card_ce6_n, card_oe_n, card_we_n;
    logic card_wait_n, card_data_oe;
    logic [7:0] wait_len = 0;
    int errors = 0, n_tests = 0, cyc = 0;
    int fw[16] = '{0,1,2,3,4,6,8,10,12,14,18,22,26,30,34,38};
    always #50 clk_sys = ~clk_sys;
    assign hready = hreadyout;
    card_strobe_ctrl i_card_strobe_ctrl (.clk_sys, .rst, .manual_rst,
        .standby, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .card_addr, .card_addr_oe,
        .card_ce5_n, .card_ce6_n, .card_oe_n, .card_we_n, .card_wait_n,
        .card_data_i, .card_data_o, .card_data_oe);
    card_device_model i_card_device_model (.clk_sys, .card_addr,
        .card_ce5_n, .card_ce6_n, .card_oe_n, .card_we_n, .wait_len,
        .card_wait_n, .card_data_i);
    // --------------------------------
    // bus access and checking
    // --------------------------------
    task chk(input string nm, input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1; htrans <= 2'b10; hwrite <= w; haddr <= {24'h0, a};
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        htrans <= 2'b00; hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
    endtask : bus
    function logic stb(input logic ar);
        return ar ? card_we_n : card_oe_n;
    endfunction : stb
    // area 6 accesses write, area 5 accesses read
    task acc(input logic ar, input logic [2:0] d, h, input logic [3:0] c,
             input int b, input logic [7:0] wt);
        int m, e, k, x;
        m = 0; e = 0; k = 0; wait_len <= wt;
        x = fw[c] + 1 + (b - 1) * (c < 2 ? 2 : fw[c] + 1);
        bus(1, 8'h00, ar ? {c[3], 4'h0, d[2], 1'b0, h[2], 2'b0, d[1:0],
            2'b0, h[1:0]} : {1'b0, c[3], 2'b0, d[2], 1'b0, h[2], 1'b0,
            d[1:0], 2'b0, h[1:0], 2'b0});
        bus(1, 8'h04, {22'h0, ar, ~ar, 1'b0, ar ? c[2:0] : 3'b0, 1'b0,
            ar ? 3'b0 : c[2:0]});
        bus(1, 8'h08, 32'h100);
        bus(1, 8'h0c, 32'hc3a5);
        bus(1, 8'h10, {24'h0, 4'(b - 1), 2'b0, ar, ar});
        while (stb(ar) === 1'b1 && m < 9) begin @(posedge clk_sys); m++; end
        chk("assert delay", m, d + 1);
        chk("select", ar ? card_ce6_n : card_ce5_n, 0);
        if (ar) chk("write data", card_data_o, 16'hc3a5);
        chk("address", card_addr, 32'h100);
        chk("data enable", card_data_oe, ar);
        while (stb(ar) === 1'b0 && e < 200) begin @(posedge clk_sys); e++; end
        if (wt > 0 && c != 0) chk("wait", e > x, 1);
        else chk("width", e, x);
        while (card_addr_oe && k < 9) begin @(posedge clk_sys); k++; end
        chk("hold", k, h + 1);
        chk("deselect", ar ? card_ce6_n : card_ce5_n, 1);
        if (!ar && c > 2)
        begin
            bus(0, 8'h14, 0);
            chk("read data", rd, (32'h100 + b - 1) ^ 32'h5a5a);
        end
        $display("test area %0d code %0d done", 5 + ar, c);
    endtask : acc
    task results;
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    // 20000 cycles is far beyond the longest run of accesses
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000) begin errors++; results(); end
    end
    initial
    begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        bus(0, 8'h00, 0); chk("timing reset", rd, 0);
        bus(0, 8'h04, 0); chk("wait reset", rd, 32'h77);
        bus(1, 8'h00, 32'hffff);
        bus(0, 8'h00, 0); chk("reserved zero", rd, 32'hcfff);
        bus(0, 8'h1c, 0); chk("unmapped", rd, 0);
        bus(1, 8'h00, 32'h1234);
        manual_rst <= 1; standby <= 1;
        repeat (6) @(posedge clk_sys);
        manual_rst <= 0; standby <= 0;
        repeat (4) @(posedge clk_sys);
        bus(0, 8'h00, 0); chk("kept", rd, 32'h0234);
        rst <= 1;
        repeat (2) @(posedge clk_sys);
        rst <= 0;
        @(posedge clk_sys);
        bus(0, 8'h00, 0); chk("cleared", rd, 0);
        $display("test registers done");
        for (int c = 0; c < 16; c++)
            acc(c[0], c[2:0], ~c[2:0], c[3:0], c % 3 + 1, 0);
        acc(0, 1, 0, 0, 1, 8);
        acc(1, 2, 1, 3, 1, 8);
        bus(0, 8'h18, 0); chk("status done", rd, 32'h2);
        bus(1, 8'h04, 0);
        bus(1, 8'h10, 0);
        bus(0, 8'h18, 0); chk("refused", rd, 32'h6);
        bus(1, 8'h18, 32'h6);
        bus(0, 8'h18, 0); chk("status clear", rd, 0);
        $display("test status done");
        results();
    end
endmodule : card_strobe_ctrl_bench
